// ==== design/psia_map.svh ====
// register indices, bit positions and reset values of the port status block
`ifndef PSIA_MAP_SVH
`define PSIA_MAP_SVH
// word indices; byte address is four times the index
`define PSIA_IDX_SUMMARY 10'h050
`define PSIA_IDX_LIVE 10'h052
`define PSIA_IDX_LATCHED 10'h054
`define PSIA_IDX_IRQ_EN 10'h056
`define PSIA_IDX_GLOBAL 10'h058
// summary register bits
`define PSIA_SUM_PORT 9
`define PSIA_SUM_LINE 8
`define PSIA_SUM_TRACE 7
`define PSIA_SUM_ALARM 6
`define PSIA_SUM_LINK 5
`define PSIA_SUM_TESTER 4
`define PSIA_SUM_FRAMER 0
// live, latched and enable bits
`define PSIA_B_RXACT 7
`define PSIA_B_TXACT 6
`define PSIA_B_OVL 2
`define PSIA_B_UNLK 1
`define PSIA_B_DONE 0
// global control register: per-port enable field and update request
`define PSIA_G_EN_LSB 1
`define PSIA_G_EN_MSB 4
`define PSIA_G_PERF_REQ 0
// reset values and implemented bit masks
`define PSIA_IE_RST 3'h0
`define PSIA_GCTL_RST 5'h00
`define PSIA_LATCH_RST 8'h00
`define PSIA_LATCH_MASK 8'hC7
`endif

// ==== design/psia_pkg.sv ====
// types of the port status interrupt aggregator
package psia_pkg;
  // enabled-and-latched request of each sub-block of the port
  typedef struct packed {
    logic line_code;
    logic trace;
    logic alarm_code;
    logic link_ctrl;
    logic error_tester;
    logic framer_ds3;
    logic framer_e3;
  } psia_sub_irq_t;

  // whole state of the block
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic done;
    logic done_d;
    logic [7:0] latched;
    logic [2:0] ie;
    logic [4:0] gctl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } psia_state_t;
endpackage

// ==== design/psia_top.sv ====
// port status and interrupt aggregation with an apb register slave
`timescale 1ns/1ps
`include "psia_map.svh"

module psia_top
  import psia_pkg::*;
#(
  parameter int AW = 12,
  parameter int PM_N = 4,
  parameter int PORT_IDX = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic driver_overload_pin,
  input wire logic rx_unlock_pin,
  input wire logic rx_line_clock_pin,
  input wire logic rx_recovered_clock,
  input wire logic tx_input_clock_pin,
  input wire logic [PM_N-1:0] update_status,
  input wire logic [PM_N-1:0] update_active,
  input wire psia_sub_irq_t sub_irq,
  input wire logic framer_is_e3,
  output logic irq,
  output logic perf_update_request
);

  // one-hot select: summary, live, latched, enable, global
  function automatic logic [4:0] reg_decode(input logic [AW-3:0] w);
    logic [4:0] s;
    s = 5'h00;
    s[0] = (w == (AW-2)'(`PSIA_IDX_SUMMARY));
    s[1] = (w == (AW-2)'(`PSIA_IDX_LIVE));
    s[2] = (w == (AW-2)'(`PSIA_IDX_LATCHED));
    s[3] = (w == (AW-2)'(`PSIA_IDX_IRQ_EN));
    s[4] = (w == (AW-2)'(`PSIA_IDX_GLOBAL));
    return s;
  endfunction

  psia_state_t st_reg;
  psia_state_t st_next;
  logic [4:0] sel;
  logic [15:0] summary;
  logic [15:0] live;
  logic gen;
  logic done_now;
  logic setup;
  logic wr;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [31:0] rd_word;

  assign gen = st_reg.gctl[PORT_IDX - 1 + `PSIA_G_EN_LSB];
  assign setup = psel & ~penable;
  // writes land only at the access edge where pready is seen high
  assign wr = psel & penable & st_reg.pready & pwrite & pstrb[0];
  assign sel = reg_decode(paddr[AW-1:2]);
  // with no update in progress the done level stays low
  assign done_now = (|update_active) & (&(update_status | ~update_active));

  always_comb begin
    summary = 16'h0000;
    summary[`PSIA_SUM_PORT] = |(st_reg.latched[2:0] & st_reg.ie);
    summary[`PSIA_SUM_LINE] = sub_irq.line_code;
    summary[`PSIA_SUM_TRACE] = sub_irq.trace;
    summary[`PSIA_SUM_ALARM] = sub_irq.alarm_code;
    summary[`PSIA_SUM_LINK] = sub_irq.link_ctrl;
    summary[`PSIA_SUM_TESTER] = sub_irq.error_tester;
    summary[`PSIA_SUM_FRAMER] = framer_is_e3 ? sub_irq.framer_e3 : sub_irq.framer_ds3;
  end

  always_comb begin
    live = 16'h0000;
    live[`PSIA_B_OVL] = st_reg.s2[0];
    live[`PSIA_B_UNLK] = st_reg.s2[1];
    live[`PSIA_B_DONE] = st_reg.done;
  end

  // clock pins are sampled at the system rate, so a line clock faster than half
  // of it may alias; any toggle still counts as activity
  always_comb begin
    set_bits = 8'h00;
    set_bits[`PSIA_B_RXACT] = (st_reg.s2[2] ^ st_reg.s3[2])
                            | (st_reg.s2[3] ^ st_reg.s3[3]);
    set_bits[`PSIA_B_TXACT] = st_reg.s2[4] ^ st_reg.s3[4];
    set_bits[`PSIA_B_OVL] = st_reg.s2[0] & ~st_reg.s3[0];
    set_bits[`PSIA_B_UNLK] = st_reg.s2[1] & ~st_reg.s3[1];
    set_bits[`PSIA_B_DONE] = st_reg.done & ~st_reg.done_d;
  end

  assign clr_bits = (wr && sel[2]) ? pwdata[7:0] : 8'h00;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (1'b1)
      sel[0]: rd_word[15:0] = summary;
      sel[1]: rd_word[15:0] = live;
      sel[2]: rd_word[7:0] = st_reg.latched;
      sel[3]: rd_word[2:0] = st_reg.ie;
      sel[4]: rd_word[4:0] = st_reg.gctl;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    if (ce) begin
      // pins from other domains pass two flops before any use
      st_next.s1 = {tx_input_clock_pin, rx_recovered_clock, rx_line_clock_pin,
                    rx_unlock_pin, driver_overload_pin};
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.done = done_now;
      st_next.done_d = st_reg.done;
      // a new event in the clearing cycle survives: set wins
      st_next.latched = ((st_reg.latched & ~clr_bits) | set_bits)
                        & `PSIA_LATCH_MASK;
      if (wr && sel[3]) begin
        st_next.ie = pwdata[2:0];
      end
      if (wr && sel[4]) begin
        st_next.gctl = pwdata[4:0];
      end
      // answer is prepared at setup so every access with ce high at setup has no wait state
      st_next.pready = setup;
      st_next.pslverr = setup & ~(|sel);
      if (setup && !pwrite) begin
        st_next.prdata = rd_word;
      end
      st_next.irq = (|summary) & gen;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.latched <= `PSIA_LATCH_RST;
      st_reg.ie <= `PSIA_IE_RST;
      st_reg.gctl <= `PSIA_GCTL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready = st_reg.pready;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign irq = st_reg.irq;
  // the host keeps this high until the done bit reads one
  assign perf_update_request = st_reg.gctl[`PSIA_G_PERF_REQ];

  // checks kept beside the logic

  port_flag_read_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup && !pwrite && sel[0]
    |=> prdata[`PSIA_SUM_PORT] == $past(|(st_reg.latched[2:0] & st_reg.ie)))
    else $error("port summary flag read wrong");

  sub_flags_read_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup && !pwrite && sel[0]
    |=> prdata[8:4] == $past({sub_irq.line_code, sub_irq.trace, sub_irq.alarm_code,
                              sub_irq.link_ctrl, sub_irq.error_tester}))
    else $error("sub-block summary flags read wrong");

  framer_flag_read_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup && !pwrite && sel[0]
    |=> prdata[`PSIA_SUM_FRAMER] ==
        $past(framer_is_e3 ? sub_irq.framer_e3 : sub_irq.framer_ds3))
    else $error("framer summary flag follows wrong framer");

  irq_raise_a: assert property (@(posedge clk) disable iff (reset)
    ce && (|summary) && gen |=> irq)
    else $error("interrupt not raised");

  irq_gate_a: assert property (@(posedge clk) disable iff (reset)
    ce && !gen |=> !irq)
    else $error("interrupt raised with port disabled");

  live_read_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup && !pwrite && sel[1]
    |=> prdata[2:1] == $past({st_reg.s2[0], st_reg.s2[1]}))
    else $error("live overload or unlock read wrong");

  done_and_a: assert property (@(posedge clk) disable iff (reset)
    ce && !(&(update_status | ~update_active)) |=> !st_reg.done)
    else $error("update done set before all updates finished");

  done_set_a: assert property (@(posedge clk) disable iff (reset)
    ce && (|update_active) && (&(update_status | ~update_active)) |=> st_reg.done)
    else $error("update done not set");

  rx_activity_a: assert property (@(posedge clk) disable iff (reset)
    ce && (st_reg.s2[2] != st_reg.s3[2]) |=> st_reg.latched[`PSIA_B_RXACT])
    else $error("receive clock activity not latched");

  tx_activity_a: assert property (@(posedge clk) disable iff (reset)
    ce && (st_reg.s2[4] != st_reg.s3[4]) |=> st_reg.latched[`PSIA_B_TXACT])
    else $error("transmit clock activity not latched");

  overload_rise_a: assert property (@(posedge clk) disable iff (reset)
    ce ##1 ce && $rose(st_reg.s2[0]) |=> st_reg.latched[`PSIA_B_OVL])
    else $error("overload rise not latched");

  pin_to_latch_a: assert property (@(posedge clk) disable iff (reset)
    ce && !rx_unlock_pin ##1 ce && rx_unlock_pin ##1 ce [*2]
    |=> st_reg.latched[`PSIA_B_UNLK])
    else $error("unlock rise not latched after sync delay");

  enable_mask_a: assert property (@(posedge clk) disable iff (reset)
    ce && ((st_reg.latched[2:0] & st_reg.ie) == 3'h0) && ((summary & 16'h01F1) == 16'h0000)
    |=> !irq)
    else $error("disabled latched bit raised interrupt");

  latch_hold_a: assert property (@(posedge clk) disable iff (reset)
    ce && st_reg.latched[`PSIA_B_OVL] && !(wr && sel[2] && pwdata[`PSIA_B_OVL])
    |=> st_reg.latched[`PSIA_B_OVL])
    else $error("latched bit lost without write one");

  latch_clear_a: assert property (@(posedge clk) disable iff (reset)
    ce && wr && sel[2] && pwdata[`PSIA_B_UNLK] && !set_bits[`PSIA_B_UNLK]
    |=> !st_reg.latched[`PSIA_B_UNLK])
    else $error("write one did not clear latched bit");

  set_wins_a: assert property (@(posedge clk) disable iff (reset)
    ce && wr && sel[2] && pwdata[`PSIA_B_DONE] && set_bits[`PSIA_B_DONE]
    |=> st_reg.latched[`PSIA_B_DONE])
    else $error("event lost during clear");

  summary_drop_a: assert property (@(posedge clk) disable iff (reset)
    ce && wr && sel[3] && (pwdata[2:0] == 3'h0)
    |=> !summary[`PSIA_SUM_PORT])
    else $error("port flag stayed after enables cleared");

  enable_reset_a: assert property (@(posedge clk)
    reset |=> st_reg.ie == `PSIA_IE_RST && !irq)
    else $error("interrupt enables not cleared by reset");

  ready_pulse_a: assert property (@(posedge clk) disable iff (reset)
    pready |=> !pready)
    else $error("pready longer than one cycle");

  unmapped_err_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup && !(|sel) |=> pready && pslverr)
    else $error("unmapped access not flagged");

  enable_write_a: assert property (@(posedge clk) disable iff (reset)
    ce && wr && sel[3] |=> st_reg.ie == $past(pwdata[2:0]))
    else $error("enable register write lost");

  overload_clear_a: assert property (@(posedge clk) disable iff (reset)
    ce && wr && sel[2] && pwdata[`PSIA_B_OVL] && !set_bits[`PSIA_B_OVL]
    |=> !st_reg.latched[`PSIA_B_OVL])
    else $error("write one did not clear overload latch");

  done_rise_a: assert property (@(posedge clk) disable iff (reset)
    ce && st_reg.done && !st_reg.done_d |=> st_reg.latched[`PSIA_B_DONE])
    else $error("update done rise not latched");

  unlock_rise_a: assert property (@(posedge clk) disable iff (reset)
    ce && st_reg.s2[1] && !st_reg.s3[1] |=> st_reg.latched[`PSIA_B_UNLK])
    else $error("unlock rise not latched");

  recovered_activity_a: assert property (@(posedge clk) disable iff (reset)
    ce && (st_reg.s2[3] != st_reg.s3[3]) |=> st_reg.latched[`PSIA_B_RXACT])
    else $error("recovered clock activity not latched");

  unused_latch_a: assert property (@(posedge clk) disable iff (reset)
    st_reg.latched[5:3] == 3'h0)
    else $error("unimplemented latched bits set");

  done_read_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup && !pwrite && sel[1]
    |=> prdata[`PSIA_B_DONE] == $past(st_reg.done))
    else $error("update done read wrong");

  live_upper_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup && !pwrite && sel[1] |=> prdata[31:3] == 29'h0)
    else $error("live register upper bits not zero");

  latched_read_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup && !pwrite && sel[2]
    |=> prdata == {24'h00_0000, $past(st_reg.latched)})
    else $error("latched register read wrong");

  summary_unused_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup && !pwrite && sel[0]
    |=> prdata[31:10] == 22'h0 && prdata[3:1] == 3'h0)
    else $error("summary unused bits not zero");

  global_write_a: assert property (@(posedge clk) disable iff (reset)
    ce && wr && sel[4] |=> st_reg.gctl == $past(pwdata[4:0]))
    else $error("global register write lost");

  perf_request_a: assert property (@(posedge clk) disable iff (reset)
    ce && wr && sel[4]
    |=> perf_update_request == $past(pwdata[`PSIA_G_PERF_REQ]))
    else $error("update request does not follow global write");

  irq_clear_a: assert property (@(posedge clk) disable iff (reset)
    ce && !(|summary) |=> !irq)
    else $error("interrupt with empty summary");

  port_irq_a: assert property (@(posedge clk) disable iff (reset)
    ce && (|(st_reg.latched[2:0] & st_reg.ie)) && gen |=> irq)
    else $error("enabled latched bit did not raise interrupt");

  ce_freeze_a: assert property (@(posedge clk) disable iff (reset)
    !ce |=> st_reg == $past(st_reg))
    else $error("state moved with clock enable low");

  err_with_ready_a: assert property (@(posedge clk) disable iff (reset)
    pslverr |-> pready)
    else $error("pslverr without pready");

  setup_ready_a: assert property (@(posedge clk) disable iff (reset)
    ce && setup |=> pready)
    else $error("no pready after setup");

  idle_ready_a: assert property (@(posedge clk) disable iff (reset)
    ce && !setup |=> !pready)
    else $error("pready without setup");

  unmapped_write_a: assert property (@(posedge clk) disable iff (reset)
    ce && wr && !(|sel)
    |=> st_reg.ie == $past(st_reg.ie) && st_reg.gctl == $past(st_reg.gctl))
    else $error("unmapped write changed a register");

  enable_hold_a: assert property (@(posedge clk) disable iff (reset)
    ce && !(wr && sel[3]) |=> st_reg.ie == $past(st_reg.ie))
    else $error("enable register changed without write");

  prdata_hold_a: assert property (@(posedge clk) disable iff (reset)
    ce && !(setup && !pwrite) |=> prdata == $past(prdata))
    else $error("read data changed without read setup");

endmodule

// ==== dv/psia_host.sv ====
// host-side apb master model of the port status block
`timescale 1ns/1ps
`include "psia_map.svh"
module psia_host #(
  parameter int AW = 12
) (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [AW-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  localparam logic [AW-1:0] A_GL = AW'({`PSIA_IDX_GLOBAL, 2'b00});
  localparam logic [AW-1:0] A_LIVE = AW'({`PSIA_IDX_LIVE, 2'b00});
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // released lines show no stale request
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // request stays up until the done bit is seen; dropping early may skip the update
  task automatic perf_update(input logic [31:0] gval);
    logic [31:0] r;
    logic e;
    xfer(1'b1, A_GL, gval | 32'h1, r, e);
    do xfer(1'b0, A_LIVE, 32'h0, r, e); while (r[`PSIA_B_DONE] !== 1'b1);
    xfer(1'b1, A_GL, gval, r, e);
  endtask
endmodule

// ==== dv/psia_top_tb.sv ====
// self-checking testbench of the port status interrupt aggregator
`timescale 1ns/1ps
`include "psia_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module psia_top_tb;
  import psia_pkg::*;
  localparam int AW = 12;
  localparam logic [AW-1:0] A_SUM = AW'({`PSIA_IDX_SUMMARY, 2'b00});
  localparam logic [AW-1:0] A_LIVE = AW'({`PSIA_IDX_LIVE, 2'b00});
  localparam logic [AW-1:0] A_LAT = AW'({`PSIA_IDX_LATCHED, 2'b00});
  localparam logic [AW-1:0] A_IE = AW'({`PSIA_IDX_IRQ_EN, 2'b00});
  localparam logic [AW-1:0] A_GL = AW'({`PSIA_IDX_GLOBAL, 2'b00});
  logic clk = 0, reset = 1, ovl = 0, unlk = 0, rxclk = 0, rcclk = 0, txclk = 0, e3 = 0;
  logic ce = 1;
  logic [3:0] upd_status = 4'h0, upd_active = 4'h0;
  psia_sub_irq_t sub = '0;
  logic psel, penable, pwrite, pready, pslverr, irq, perf_req, err;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int num_errors = 0, check_count = 0;
  always #50 clk = ~clk;
  // counters finish their snapshot one cycle after the request
  always @(posedge clk) upd_status <= {4{perf_req}} & upd_active;
  psia_host #(.AW(AW)) host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  psia_top #(.AW(AW), .PM_N(4), .PORT_IDX(1)) dut_u (.clk(clk), .reset(reset), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .driver_overload_pin(ovl), .rx_unlock_pin(unlk), .rx_line_clock_pin(rxclk),
    .rx_recovered_clock(rcclk), .tx_input_clock_pin(txclk), .update_status(upd_status),
    .update_active(upd_active), .sub_irq(sub), .framer_is_e3(e3), .irq(irq),
    .perf_update_request(perf_req));
  task automatic rd(input logic [AW-1:0] a);
    host_u.xfer(1'b0, a, 32'h0, rdata, err);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    host_u.xfer(1'b1, a, d, r, err);
  endtask
  // pin sync, latch and irq register together take four edges
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_reset;
    rd(A_IE);
    `CHK(rdata, 32'h0)
    `CHK(irq, 1'b0)
    host_u.xfer(1'b0, 12'h3FC, 32'h0, rdata, err);
    `CHK(err, 1'b1)
    wr(A_IE, 32'hFFFF_FFFF);
    rd(A_IE);
    `CHK(rdata, 32'h7)
    wr(A_IE, 32'h0);
  endtask
  task automatic t_live;
    @(posedge clk) ovl <= 1'b1;
    settle;
    rd(A_LIVE);
    `CHK(rdata, 32'h4)
    @(posedge clk) unlk <= 1'b1;
    settle;
    rd(A_LIVE);
    `CHK(rdata, 32'h6)
    @(posedge clk) ovl <= 1'b0;
    unlk <= 1'b0;
    settle;
    rd(A_LIVE);
    `CHK(rdata, 32'h0)
    wr(A_LAT, 32'h0);
    rd(A_LAT);
    `CHK(rdata, 32'h6)
    wr(A_LAT, 32'h2);
    rd(A_LAT);
    `CHK(rdata, 32'h4)
  endtask
  task automatic t_port;
    rd(A_SUM);
    `CHK(rdata, 32'h0)
    wr(A_IE, 32'h4);
    rd(A_SUM);
    `CHK(rdata, 32'h200)
    settle;
    `CHK(irq, 1'b0)
    wr(A_GL, 32'h2);
    settle;
    `CHK(irq, 1'b1)
    wr(A_IE, 32'h3);
    rd(A_SUM);
    `CHK(rdata, 32'h0)
    settle;
    `CHK(irq, 1'b0)
    wr(A_IE, 32'h4);
    wr(A_LAT, 32'h4);
    rd(A_SUM);
    `CHK(rdata, 32'h0)
    wr(A_IE, 32'h0);
  endtask
  task automatic t_clk;
    for (int k = 0; k < 3; k++) begin
      for (int n = 0; n < 6; n++) begin
        @(posedge clk);
        if (k == 0) rxclk <= ~rxclk;
        else if (k == 1) rcclk <= ~rcclk;
        else txclk <= ~txclk;
      end
      settle;
      rd(A_LAT);
      `CHK(rdata, (k == 2) ? 32'h40 : 32'h80)
      wr(A_LAT, 32'hC7);
    end
  endtask
  task automatic t_sub;
    logic [31:0] tab [7] = '{32'h1, 32'h1, 32'h10, 32'h20, 32'h40, 32'h80, 32'h100};
    logic [31:0] exp;
    for (int i = 0; i < 7; i++) begin
      for (int e = 0; e < 2; e++) begin
        @(posedge clk) sub <= psia_sub_irq_t'(7'h1 << i);
        e3 <= e[0];
        settle;
        exp = ((i == 1 && e == 1) || (i == 0 && e == 0)) ? 32'h0 : tab[i];
        rd(A_SUM);
        `CHK(rdata, exp)
        `CHK(irq, |exp)
      end
    end
    wr(A_GL, 32'h0);
    settle;
    `CHK(irq, 1'b0)
    @(posedge clk) sub <= '0;
  endtask
  task automatic t_perf;
    @(posedge clk) upd_active <= 4'h5;
    settle;
    rd(A_LIVE);
    `CHK(rdata, 32'h0)
    host_u.perf_update(32'h0);
    rd(A_LAT);
    `CHK(rdata, 32'h1)
  endtask
  // a pin pulse that lives only while the enable is low must leave no latch
  task automatic t_ce;
    @(posedge clk) ce <= 1'b0;
    ovl <= 1'b1;
    repeat (6) @(posedge clk);
    @(posedge clk) ovl <= 1'b0;
    ce <= 1'b1;
    settle;
    rd(A_LAT);
    `CHK(rdata, 32'h1)
  endtask
  task automatic end_sim;
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_live;
    t_port;
    t_clk;
    t_sub;
    t_perf;
    t_ce;
    end_sim;
  end
  initial begin
    #1000000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim;
  end
endmodule
